// ==== hw/ebw_bus_ctrl.v ====
// Functional notes
// - with handshake on, wait field top bit picks synchronous or asynchronous ready sampling.
// - wait field bits 0-2 give 0-7 wait states, added to the ready handshake.
// - handshake on and zero waits: ready sampled at once, legacy behaviour.
// - one to seven waits are inserted first, ready ignored meanwhile.
// - after waits ready low ends cycle; high stretches until it goes low.
// - asynchronous mode with zero waits first samples ready at the address strobe falling edge.
// - alternate config register holds a full independent set of bus settings.
// - accesses inside the window use the alternate configuration.
// - accesses outside the window use the system configuration.
// - range size 000..100 gives 2K,16K,32K,64K,128K; 101-111 reserved.
// - range select bits 3-9 hold window start; bits 10-15 reserved.
// - only start bits relevant to the size are compared; window self-aligned.
// - address space is 256K; a 128K window starts at 0 or 128K.
// - reset clears alternate config to zero; boot pins are not copied there.
// - alternate config stays inactive until its enable bit is set.
// - alternate config never affects on-chip rom mapping or enabling.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "ebw_defs.vh"
module ebw_bus_ctrl #(
    parameter AW = 18
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire [1:0] i_reg_addr,
    input wire [15:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_reg_rd,
    output reg [15:0] o_reg_rdata,
    input wire i_boot_bus_type_pin_lo,
    input wire i_boot_bus_type_pin_hi,
    input wire i_boot_external_start_pin_n,
    input wire i_acc_req,
    input wire [AW-1:0] i_acc_addr,
    output wire o_acc_busy,
    output wire o_acc_done,
    output wire o_ale,
    input wire i_ready_n,
    output reg o_cfg_alt,
    output reg [1:0] o_bus_type,
    output wire o_rom_enable,
    output wire o_rom_seg1
);

localparam ST_IDLE = 5'h01;
localparam ST_ALE = 5'h02;
localparam ST_WAIT = 5'h04;
localparam ST_RDY = 5'h08;
localparam ST_DONE = 5'h10;

reg [15:0] sys_cfg_ff;
reg [15:0] alt_cfg_ff;
reg [9:0] alt_rsel_ff;
reg strap_done_ff;
reg [4:0] state_ff;
reg [4:0] nxt_state;
reg [3:0] wcnt_ff;
reg [3:0] nxt_wcnt;
reg hs_ff;
reg sync_ff;
reg ready_n_ff;
reg alt_sel_ff;
reg [1:0] btyp_ff;

// start-bit compare mask per range size; zero valid flag for reserved
function [7:0] size_mask;
    input [2:0] sz;
    begin
        case (sz)
            `EBW_SZ_2K: size_mask = 8'hff;
            `EBW_SZ_16K: size_mask = 8'hf8;
            `EBW_SZ_32K: size_mask = 8'hf0;
            `EBW_SZ_64K: size_mask = 8'he0;
            `EBW_SZ_128K: size_mask = 8'hc0;
            default: size_mask = 8'h00;
        endcase
    end
endfunction

// write strobe decode per register index
function wr_hit;
    input wr;
    input [1:0] addr;
    input [1:0] idx;
    begin
        wr_hit = wr && (addr == idx);
    end
endfunction

wire sys_wr_w = wr_hit(i_reg_wr, i_reg_addr, `EBW_IDX_SYS_CFG);
wire alt_wr_w = wr_hit(i_reg_wr, i_reg_addr, `EBW_IDX_ALT_CFG);
wire rsel_wr_w = wr_hit(i_reg_wr, i_reg_addr, `EBW_IDX_ALT_RSEL);

wire [7:0] mask_w = size_mask(alt_rsel_ff[`EBW_RSEL_SZ_MSB:`EBW_RSEL_SZ_LSB]);
wire [6:0] start_w = alt_rsel_ff[`EBW_RSEL_ST_MSB:`EBW_RSEL_ST_LSB];
// top 7 address bits are 2K blocks of the 256K space
wire [6:0] blk_w = i_acc_addr[AW-1:AW-7];
wire win_hit = mask_w[7] && (((blk_w ^ start_w) & mask_w[6:0]) == 7'h00);
wire use_alt = alt_cfg_ff[`EBW_CFG_ACT_BIT] && win_hit;
wire [15:0] cfg_w = use_alt ? alt_cfg_ff : sys_cfg_ff;
wire hs_w = cfg_w[`EBW_CFG_HS_BIT];
// handshake on: three bits of waits; off: whole field counts
wire [3:0] wait_w = hs_w ? {1'b0, cfg_w[`EBW_CFG_WAIT_MSB:`EBW_CFG_WAIT_LSB]} :
    cfg_w[`EBW_CFG_SYNC_BIT:`EBW_CFG_WAIT_LSB];
// synchronous mode looks at the registered copy of ready
wire rdy_smp_n = sync_ff ? ready_n_ff : i_ready_n;

// request taken only while idle; later ones wait
wire take_w = (state_ff == ST_IDLE) && i_acc_req;

always @* begin
    nxt_state = state_ff;
    nxt_wcnt = wcnt_ff;
    case (state_ff)
        ST_IDLE: begin
            if (i_acc_req) begin
                nxt_state = ST_ALE;
                nxt_wcnt = wait_w;
            end
        end
        ST_ALE: begin
            if (wcnt_ff != 4'h0) begin
                nxt_state = ST_WAIT;
            end else if (!hs_ff) begin
                nxt_state = ST_DONE;
            end else if (!sync_ff && !i_ready_n) begin
                nxt_state = ST_DONE;
            end else begin
                nxt_state = ST_RDY;
            end
        end
        ST_WAIT: begin
            nxt_wcnt = wcnt_ff - 4'h1;
            if (wcnt_ff == 4'h1) begin
                nxt_state = hs_ff ? ST_RDY : ST_DONE;
            end
        end
        ST_RDY: begin
            if (!rdy_smp_n) begin
                nxt_state = ST_DONE;
            end
        end
        ST_DONE: begin
            nxt_state = ST_IDLE;
        end
        default: begin
            nxt_state = ST_IDLE;
        end
    endcase
end

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        state_ff <= ST_IDLE;
        wcnt_ff <= 4'h0;
    end else begin
        state_ff <= nxt_state;
        wcnt_ff <= nxt_wcnt;
    end
end

// one-cycle copy of ready for synchronous sampling
always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        ready_n_ff <= 1'b1;
    end else begin
        ready_n_ff <= i_ready_n;
    end
end

// access settings frozen at the take, so a write in flight cannot bend the cycle
always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        hs_ff <= 1'b0;
    end else if (take_w) begin
        hs_ff <= hs_w;
    end
end

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        sync_ff <= 1'b0;
    end else if (take_w) begin
        sync_ff <= cfg_w[`EBW_CFG_SYNC_BIT];
    end
end

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        alt_sel_ff <= 1'b0;
    end else if (take_w) begin
        alt_sel_ff <= use_alt;
    end
end

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        btyp_ff <= 2'h0;
    end else if (take_w) begin
        btyp_ff <= cfg_w[`EBW_CFG_BTYP_MSB:`EBW_CFG_BTYP_LSB];
    end
end

// strap capture runs once, on the first edge after release
always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        strap_done_ff <= 1'b0;
    end else begin
        strap_done_ff <= 1'b1;
    end
end

// system config: a write wins over the strap capture
always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        sys_cfg_ff <= `EBW_CFG_RST;
    end else if (sys_wr_w) begin
        sys_cfg_ff <= i_reg_wdata & `EBW_CFG_WMASK;
    end else if (!strap_done_ff) begin
        sys_cfg_ff[`EBW_CFG_BTYP_MSB:`EBW_CFG_BTYP_LSB] <=
            {i_boot_bus_type_pin_hi, i_boot_bus_type_pin_lo};
        sys_cfg_ff[`EBW_CFG_ACT_BIT] <= ~i_boot_external_start_pin_n;
    end
end

// alternate config: cleared on reset, never loaded from the straps
always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        alt_cfg_ff <= `EBW_CFG_RST;
    end else if (alt_wr_w) begin
        alt_cfg_ff <= i_reg_wdata & `EBW_CFG_WMASK;
    end
end

// range select: reserved upper bits are not stored
always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        alt_rsel_ff <= 10'h000;
    end else if (rsel_wr_w) begin
        alt_rsel_ff <= i_reg_wdata[`EBW_RSEL_ST_MSB:`EBW_RSEL_SZ_LSB];
    end
end

wire [15:0] status_w = {10'h000, alt_sel_ff, state_ff};

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
        case (i_reg_addr)
            `EBW_IDX_SYS_CFG: o_reg_rdata <= sys_cfg_ff;
            `EBW_IDX_ALT_CFG: o_reg_rdata <= alt_cfg_ff;
            `EBW_IDX_ALT_RSEL: o_reg_rdata <= {6'h00, alt_rsel_ff};
            default: o_reg_rdata <= status_w;
        endcase
    end else begin
        o_reg_rdata <= 16'h0000;
    end
end

// which configuration the last access used
always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        o_cfg_alt <= 1'b0;
    end else begin
        o_cfg_alt <= alt_sel_ff;
    end
end

// bus type of the last access
always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        o_bus_type <= 2'h0;
    end else begin
        o_bus_type <= btyp_ff;
    end
end

assign o_acc_busy = (state_ff != ST_IDLE);
assign o_ale = (state_ff == ST_ALE);
assign o_acc_done = (state_ff == ST_DONE);
// rom decode looks at the system config only
assign o_rom_enable = !sys_cfg_ff[`EBW_CFG_ACT_BIT] &&
    (sys_cfg_ff[`EBW_CFG_BTYP_MSB:`EBW_CFG_BTYP_LSB] < `EBW_BTYP_ROM_OFF);
assign o_rom_seg1 = o_rom_enable &&
    (sys_cfg_ff[`EBW_CFG_BTYP_MSB:`EBW_CFG_BTYP_LSB] == `EBW_BTYP_ROM_SEG1);

endmodule // ebw_bus_ctrl
`default_nettype wire

// ==== inc/ebw_defs.vh ====
`ifndef EBW_DEFS_VH
`define EBW_DEFS_VH
// register indices on the plain port
`define EBW_IDX_SYS_CFG 2'h0
`define EBW_IDX_ALT_CFG 2'h1
`define EBW_IDX_ALT_RSEL 2'h2
`define EBW_IDX_STATUS 2'h3
// configuration word layout, shared by both config registers
`define EBW_CFG_WAIT_LSB 0
`define EBW_CFG_WAIT_MSB 2
`define EBW_CFG_SYNC_BIT 3
`define EBW_CFG_HS_BIT 4
`define EBW_CFG_BTYP_LSB 6
`define EBW_CFG_BTYP_MSB 7
`define EBW_CFG_ACT_BIT 10
`define EBW_CFG_WMASK 16'h04df
`define EBW_CFG_RST 16'h0000
// range select layout
`define EBW_RSEL_SZ_LSB 0
`define EBW_RSEL_SZ_MSB 2
`define EBW_RSEL_ST_LSB 3
`define EBW_RSEL_ST_MSB 9
`define EBW_RSEL_WMASK 16'h03ff
`define EBW_RSEL_RST 16'h0000
// range size codes
`define EBW_SZ_2K 3'h0
`define EBW_SZ_16K 3'h1
`define EBW_SZ_32K 3'h2
`define EBW_SZ_64K 3'h3
`define EBW_SZ_128K 3'h4
// bus type codes: EBW_BTYP_ROM_OFF and above turn the on-chip rom off; EBW_BTYP_ROM_SEG1 maps rom segment 1
`define EBW_BTYP_ROM_OFF 2'h2
`define EBW_BTYP_ROM_SEG1 2'h1
`endif

// ==== test/ebw_bus_ctrl_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module ebw_bus_ctrl_checker (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [1:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] o_reg_rdata,
    input wire logic i_acc_req,
    input wire logic o_acc_busy,
    input wire logic o_acc_done,
    input wire logic o_ale,
    input wire logic o_cfg_alt,
    input wire logic o_rom_enable,
    input wire logic o_rom_seg1
);
    logic alt_en_ff;
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) alt_en_ff <= 1'b0;
        else if (i_reg_wr && i_reg_addr == 2'h1 && i_reg_wdata[10]) alt_en_ff <= 1'b1;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_take;
        !o_acc_busy && i_acc_req;
    endsequence
    sequence s_strobe;
        o_ale && o_acc_busy ##1 !o_ale;
    endsequence
    AST_TAKE_ALE: assert property (s_take |=> s_strobe)
        else $error("no address strobe after take");
    AST_DONE_GAP: assert property (o_acc_done |=> !o_acc_busy)
        else $error("busy after done");
    AST_DONE_BUSY: assert property (o_acc_done |-> o_acc_busy && !o_ale)
        else $error("done outside busy or with strobe");
    AST_BUSY_ALE: assert property ($rose(o_acc_busy) |-> o_ale)
        else $error("busy started without strobe");
    AST_RD_IDLE: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 16'h0000)
        else $error("read data outside read slot");
    AST_RSEL_RSV: assert property ($past(i_reg_rd) && $past(i_reg_addr) == 2'h2 |-> o_reg_rdata[15:10] == 6'h00)
        else $error("range select reserved bits set");
    AST_ROM_ALT: assert property (i_reg_wr && i_reg_addr == 2'h1 |=> $stable(o_rom_enable) && $stable(o_rom_seg1))
        else $error("alt config changed rom mapping");
    AST_ALT_OFF: assert property (!alt_en_ff |-> !o_cfg_alt)
        else $error("alt config used while disabled");
endmodule // ebw_bus_ctrl_checker
bind ebw_bus_ctrl ebw_bus_ctrl_checker u_chk (.i_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
    .o_reg_rdata, .i_acc_req, .o_acc_busy, .o_acc_done, .o_ale, .o_cfg_alt, .o_rom_enable, .o_rom_seg1);
`default_nettype wire

// ==== test/ebw_ext_dev.sv ====
`timescale 1ns/100ps
`default_nettype none
module ebw_ext_dev (
    input wire logic i_clk,
    input wire logic i_ale,
    input wire logic i_done,
    input wire logic [3:0] i_dly,
    output logic o_ready_n
);
    logic act_ff = 1'b0;
    logic [3:0] cnt_ff = 4'h0;
    always @(posedge i_clk) begin
        if (i_ale) begin
            act_ff <= 1'b1;
            cnt_ff <= 4'h1;
        end else if (i_done) act_ff <= 1'b0;
        else if (cnt_ff != 4'hf) cnt_ff <= cnt_ff + 4'h1;
    end
    // valid from the strobe on; idle high as if pulled up
    assign o_ready_n = !((i_ale && i_dly == 4'h0) || (act_ff && cnt_ff >= i_dly));
endmodule // ebw_ext_dev
`default_nettype wire

// ==== test/ext_bus_wait_ready_range_select_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module ext_bus_wait_ready_range_select_tb_top;
    logic i_clk, i_rst_n, i_reg_wr, i_reg_rd, i_acc_req, ready_n, o_acc_busy, o_acc_done, o_ale, o_cfg_alt;
    logic o_rom_enable, o_rom_seg1, en;
    logic rd_d = 1'b0, done_d = 1'b0;
    logic [1:0] i_reg_addr, o_bus_type;
    logic [15:0] i_reg_wdata, o_reg_rdata, rs, sysw, altw;
    logic [17:0] i_acc_addr;
    logic [3:0] dly;
    logic [7:0] cyc, lat_s;
    logic [10:0] e;
    logic [15:0] rq[$];
    logic [10:0] aq[$];
    int errors = 0, samples_checked = 0;
    localparam logic [15:0] RS_TAB [4] = '{16'h0009, 16'h0204, 16'h0015, 16'h00f0};
    ebw_bus_ctrl uut (.i_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
        .i_boot_bus_type_pin_lo(1'b1), .i_boot_bus_type_pin_hi(1'b0), .i_boot_external_start_pin_n(1'b0),
        .i_acc_req, .i_acc_addr, .o_acc_busy, .o_acc_done, .o_ale, .i_ready_n(ready_n), .o_cfg_alt,
        .o_bus_type, .o_rom_enable, .o_rom_seg1);
    ebw_ext_dev dev (.i_clk, .i_ale(o_ale), .i_done(o_acc_done), .i_dly(dly), .o_ready_n(ready_n));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("errors=%0d checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task bus(input logic w, input logic [1:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= w;
        i_reg_rd <= !w;
        if (!w) rq.push_back(d);
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b0;
    endtask
    function logic inwin(input logic [17:0] a, input logic [15:0] r);
        int k;
        k = (r[2:0] == 3'h0) ? 7 : 5 - r[2:0];
        return (r[2:0] <= 3'h4) && (((a[17:11] ^ r[9:3]) >> (7 - k)) == 7'h00);
    endfunction
    task acc(input logic [17:0] a);
        logic alt;
        logic [15:0] w;
        int m, t;
        alt = en && inwin(a, rs);
        w = alt ? altw : sysw;
        t = $urandom % 13;
        if (!w[4]) m = w[3:0];
        else if (w[3]) m = ((w[2:0] > t) ? w[2:0] : t) + 1;
        else begin
            m = (w[2:0] == 3'h0) ? 0 : w[2:0] + 1;
            if (t > m) m = t;
        end
        aq.push_back({8'(m + 1), alt, alt ? 2'h2 : 2'h3});
        @(posedge i_clk);
        i_acc_addr <= a;
        i_acc_req <= 1'b1;
        dly <= 4'(t);
        @(posedge i_clk);
        i_acc_req <= 1'b0;
        repeat (30) if (o_acc_done !== 1'b1) @(posedge i_clk);
        @(posedge i_clk);
    endtask
    always @(posedge i_clk) begin
        rd_d <= i_reg_rd;
        done_d <= o_acc_done;
        cyc <= o_ale ? 8'd1 : cyc + 8'd1;
        if (o_acc_done) lat_s <= cyc;
        if (rd_d) chk(o_reg_rdata, rq.pop_front());
        if (done_d) begin
            e = aq.pop_front();
            chk({8'h00, lat_s}, {8'h00, e[10:3]});
            chk({15'h0, o_cfg_alt}, {15'h0, e[2]});
            chk({14'h0, o_bus_type}, {14'h0, e[1:0]});
        end
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        results;
    end
    initial begin
        {i_rst_n, i_reg_wr, i_reg_rd, i_acc_req, en} = 5'h00;
        {i_reg_addr, i_reg_wdata, i_acc_addr, dly, rs, sysw, altw} = 0;
        void'($urandom(29639));
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        bus(1'b0, 2'h0, 16'h0440);
        bus(1'b0, 2'h1, 16'h0000);
        bus(1'b1, 2'h2, 16'hffff);
        bus(1'b0, 2'h2, 16'h03ff);
        foreach (RS_TAB[i]) begin
            rs = RS_TAB[i];
            en = 1'b0;
            sysw = 16'h04c0 | 16'($urandom & 16'h1f);
            altw = 16'h0080 | 16'($urandom & 16'h1f);
            bus(1'b1, 2'h2, rs);
            bus(1'b1, 2'h0, sysw);
            bus(1'b1, 2'h1, altw);
            acc({rs[9:3], 11'h000});
            bus(1'b1, 2'h1, altw | 16'h0400);
            en = 1'b1;
            bus(1'b0, 2'h1, altw | 16'h0400);
            chk({15'h0, o_rom_enable}, 16'h0000);
            repeat (10) acc(($urandom & 1) ? {rs[9:3], 11'($urandom)} : 18'($urandom));
        end
        bus(1'b1, 2'h0, 16'h0040);
        bus(1'b1, 2'h1, 16'h0000);
        chk({14'h0, o_rom_enable, o_rom_seg1}, 16'h0003);
        results;
    end
endmodule // ext_bus_wait_ready_range_select_tb_top
`default_nettype wire
